// ===== inc/autr_map.svh
// Register offsets, field positions, reset values and bit timing counts
`ifndef AUTR_MAP_SVH
`define AUTR_MAP_SVH

`define AUTR_OFS_CTRL 8'h00
`define AUTR_OFS_BAUD 8'h04
`define AUTR_OFS_TXB 8'h08
`define AUTR_OFS_RXB 8'h0c
`define AUTR_OFS_STAT 8'h10

`define AUTR_CTRL_EN 0
`define AUTR_CTRL_TX_ENABLE_BIT 1
`define AUTR_CTRL_RX_ENABLE_BIT 2
`define AUTR_CTRL_MODE 4
`define AUTR_CTRL_POL 8
`define AUTR_CTRL_HS 9
`define AUTR_CTRL_TXIE 10
`define AUTR_CTRL_TMIE 11
`define AUTR_CTRL_RST 12'h000
`define AUTR_BAUD_RST 16'h0000

`define AUTR_STAT_TXFREE 0
`define AUTR_STAT_TXMT 1
`define AUTR_STAT_RXAVAIL 2
`define AUTR_STAT_FERR 3
`define AUTR_STAT_RXFULL 4

`define AUTR_RXB_FERR 8
`define AUTR_RXB_VALID 9

`define AUTR_MODE_8N 4'h0
`define AUTR_MODE_7N 4'h1
`define AUTR_MODE_8O 4'h2
`define AUTR_MODE_8E 4'h3

`define AUTR_LAST_NORM 4'hf
`define AUTR_LAST_HS 4'h3
`define AUTR_EARLY_A 4'h1
`define AUTR_EARLY_B 4'h2
`define AUTR_SMP_A 4'h7
`define AUTR_SMP_B 4'h8
`define AUTR_SMP_C 4'h9
`define AUTR_SMP_HS 4'h2

`define AUTR_RESP_OKAY 2'h0
`define AUTR_RESP_SLVERR 2'h2

`endif

// ===== inc/autr_pkg.sv
// Types shared by the serial transmitter and receiver
package autr_pkg;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } autr_tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } autr_rx_state_e;

endpackage : autr_pkg

// ===== hw/autr_rx_fifo.sv
// Small receive FIFO with registered head-of-queue output
`timescale 1ns/1ps
`default_nettype none

module autr_rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flush,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_pop,
  output logic [WIDTH-1:0] rd_data_q,
  output logic [$clog2(DEPTH):0] count_q
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic push_ok;
  logic pop_ok;
  logic [AW:0] left;

  assign push_ok = wr_valid && (count_q < (AW+1)'(DEPTH));
  assign pop_ok = rd_pop && (count_q != '0);
  assign rd_ptr_d = pop_ok ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign left = pop_ok ? count_q - 1'b1 : count_q;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mem_q[gi] <= '0;
        end else if (push_ok && wr_ptr_q == AW'(gi)) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      rd_ptr_q <= rd_ptr_d;
      count_q <= left + (AW+1)'(push_ok);
    end
  end

  // Head word follows the queue, bypassing a write into an empty queue
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      rd_data_q <= '0;
    end else if (left != '0) begin
      rd_data_q <= mem_q[rd_ptr_d];
    end else if (push_ok) begin
      rd_data_q <= wr_data;
    end else begin
      rd_data_q <= '0;
    end
  end

endmodule : autr_rx_fifo

`default_nettype wire

// ===== hw/autr_core.sv
// Asynchronous serial transmitter and receiver with AXI4-Lite registers
// Functional notes
// - Transmitter runs only with enables and mode 0-3
// - Busy enabled transmitter drives pin, else direction control
// - Holding buffer write starts sending, loads idle shifter
// - Queued character loads at previous stop bit start
// - Queued start bit follows stop bit, no gap
// - Polarity bit inverts whole transmit waveform including idle
// - Buffer-free flag set when enabled and buffer empty
// - Buffer-free flag read-only; enable only gates request
// - Shifter-empty flag tracks idle shifter; enable raises request
// - Seven-bit mode sends low seven bits only
// - Parity modes append even or odd ninth bit
// - Receiver runs only with enables and mode 0-3
// - Completed characters enter two-entry receive FIFO
// - High-speed receive: four ticks, one centre sample
// - Normal receive: sixteen ticks, three samples per bit
// - Falling edge starts; normal mode checks leading edge
// - Both early samples high means glitch, silent restart
// - Start sampled 7,8,9; under two lows aborts
// - Valid start; counter wraps at 16 into data
// - Data bits majority of 7,8,9, LSB first
// - Stop bit sampled; zero flags framing error
// - Both directions LSB first, shared format and rate
// - Low start, 7/8 data, optional ninth, high stop
`timescale 1ns/1ps
`default_nettype none

`include "autr_map.svh"

module autr_core #(
  parameter int ADDR_W = 8,
  parameter logic [15:0] BAUD_DIV_RST = `AUTR_BAUD_RST
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_direction_ctrl,
  input wire logic rx_in,
  output logic tx_out_q,
  output logic tx_oe_q,
  output logic tx_irq_q
);

  // Bus slave
  logic aw_hold_q, w_hold_q, aw_take, w_take, do_write, ar_take;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [11:0] ctrl_q;
  logic [15:0] baud_divisor_q;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_hold_q <= do_write ? 1'b0 : (aw_hold_q || aw_take);
      w_hold_q <= do_write ? 1'b0 : (w_hold_q || w_take);
      s_axi_awready <= !(do_write ? 1'b0 : (aw_hold_q || aw_take));
      s_axi_wready <= !(do_write ? 1'b0 : (w_hold_q || w_take));
    end
  end

  logic wr_ctrl, wr_baud, wr_txb, wr_known;
  assign wr_ctrl = awaddr_q[7:0] == `AUTR_OFS_CTRL;
  assign wr_baud = awaddr_q[7:0] == `AUTR_OFS_BAUD;
  assign wr_txb = do_write && awaddr_q[7:0] == `AUTR_OFS_TXB && wstrb_q[0];
  assign wr_known = wr_ctrl || wr_baud
    || awaddr_q[7:0] == `AUTR_OFS_TXB;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AUTR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `AUTR_RESP_OKAY : `AUTR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `AUTR_CTRL_RST;
      baud_divisor_q <= BAUD_DIV_RST;
    end else if (do_write) begin
      if (wr_ctrl && wstrb_q[0]) begin
        ctrl_q[7:0] <= wdata_q[7:0];
      end
      if (wr_ctrl && wstrb_q[1]) begin
        ctrl_q[11:8] <= wdata_q[11:8];
      end
      if (wr_baud && wstrb_q[0]) begin
        baud_divisor_q[7:0] <= wdata_q[7:0];
      end
      if (wr_baud && wstrb_q[1]) begin
        baud_divisor_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  logic module_en, tx_enable_bit, rx_enable_bit, tx_polarity;
  logic baud_speed_select, tx_buffer_free_irq_en, tx_shifter_empty_irq_en;
  logic [3:0] mode;
  logic async_mode, tx_run, rx_run;
  logic [3:0] bit_last;

  assign module_en = ctrl_q[`AUTR_CTRL_EN];
  assign tx_enable_bit = ctrl_q[`AUTR_CTRL_TX_ENABLE_BIT];
  assign rx_enable_bit = ctrl_q[`AUTR_CTRL_RX_ENABLE_BIT];
  assign mode = ctrl_q[`AUTR_CTRL_MODE +: 4];
  assign tx_polarity = ctrl_q[`AUTR_CTRL_POL];
  assign baud_speed_select = ctrl_q[`AUTR_CTRL_HS];
  assign tx_buffer_free_irq_en = ctrl_q[`AUTR_CTRL_TXIE];
  assign tx_shifter_empty_irq_en = ctrl_q[`AUTR_CTRL_TMIE];
  assign async_mode = mode[3:2] == 2'b00;
  assign tx_run = module_en && tx_enable_bit && async_mode;
  assign rx_run = module_en && rx_enable_bit && async_mode;
  assign bit_last = baud_speed_select ? `AUTR_LAST_HS : `AUTR_LAST_NORM;

  // Baud tick
  logic [15:0] baud_cnt_q;
  logic tick_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_en) begin
      baud_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= baud_cnt_q == '0;
      baud_cnt_q <= (baud_cnt_q == '0) ? baud_divisor_q
        : baud_cnt_q - 16'h0001;
    end
  end

  // Transmitter
  autr_pkg::autr_tx_state_e tx_state_q;
  logic [7:0] tx_holding_buffer;
  logic hb_full_q, pend_q, tx_par_q;
  logic [7:0] tx_shift_reg;
  logic [3:0] tx_tcnt_q, tx_bitn_q, tx_nbits;
  logic tx_bit_end, tx_parity_on, tx_level;
  logic [7:0] hb_load;

  assign tx_bit_end = tick_q && tx_tcnt_q == bit_last;
  assign tx_nbits = (mode == `AUTR_MODE_7N) ? 4'h7 : 4'h8;
  assign tx_parity_on = mode == `AUTR_MODE_8O || mode == `AUTR_MODE_8E;
  assign hb_load = (mode == `AUTR_MODE_7N) ? {1'b0, tx_holding_buffer[6:0]}
    : tx_holding_buffer;

  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_run) begin
      tx_state_q <= autr_pkg::TX_IDLE;
      hb_full_q <= 1'b0;
      pend_q <= 1'b0;
      tx_tcnt_q <= '0;
      tx_bitn_q <= '0;
      tx_shift_reg <= '0;
      tx_par_q <= 1'b0;
      tx_holding_buffer <= '0;
    end else begin
      if (wr_txb && !hb_full_q) begin
        tx_holding_buffer <= wdata_q[7:0];
        hb_full_q <= 1'b1;
      end
      if (tx_state_q != autr_pkg::TX_IDLE && tick_q) begin
        tx_tcnt_q <= tx_bit_end ? 4'h0 : tx_tcnt_q + 4'h1;
      end
      case (tx_state_q)
        autr_pkg::TX_IDLE: begin
          if (hb_full_q) begin
            tx_shift_reg <= hb_load;
            tx_par_q <= ^hb_load ^ (mode == `AUTR_MODE_8O);
            hb_full_q <= 1'b0;
            tx_tcnt_q <= '0;
            tx_state_q <= autr_pkg::TX_START;
          end
        end
        autr_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_bitn_q <= '0;
            tx_state_q <= autr_pkg::TX_DATA;
          end
        end
        autr_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bitn_q <= tx_bitn_q + 4'h1;
            if (tx_bitn_q == tx_nbits - 4'h1) begin
              tx_state_q <= tx_parity_on ? autr_pkg::TX_PAR
                : autr_pkg::TX_STOP;
              if (!tx_parity_on && hb_full_q) begin
                tx_shift_reg <= hb_load;
                tx_par_q <= ^hb_load ^ (mode == `AUTR_MODE_8O);
                hb_full_q <= 1'b0;
                pend_q <= 1'b1;
              end
            end
          end
        end
        autr_pkg::TX_PAR: begin
          if (tx_bit_end) begin
            tx_state_q <= autr_pkg::TX_STOP;
            if (hb_full_q) begin
              tx_shift_reg <= hb_load;
              tx_par_q <= ^hb_load ^ (mode == `AUTR_MODE_8O);
              hb_full_q <= 1'b0;
              pend_q <= 1'b1;
            end
          end
        end
        autr_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            pend_q <= 1'b0;
            tx_state_q <= pend_q ? autr_pkg::TX_START
              : autr_pkg::TX_IDLE;
          end
        end
        default: tx_state_q <= autr_pkg::TX_IDLE;
      endcase
    end
  end

  always_comb begin
    case (tx_state_q)
      autr_pkg::TX_START: tx_level = 1'b0;
      autr_pkg::TX_DATA: tx_level = tx_shift_reg[0];
      autr_pkg::TX_PAR: tx_level = tx_par_q;
      default: tx_level = 1'b1;
    endcase
  end

  logic tx_free, tx_empty;
  assign tx_free = tx_run && !hb_full_q;
  assign tx_empty = tx_state_q == autr_pkg::TX_IDLE && !hb_full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_q <= 1'b1;
      tx_oe_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      tx_out_q <= tx_level ^ tx_polarity;
      tx_oe_q <= (tx_run && tx_state_q != autr_pkg::TX_IDLE)
        || !pin_direction_ctrl;
      tx_irq_q <= (tx_free && tx_buffer_free_irq_en)
        || (tx_empty && tx_shifter_empty_irq_en);
    end
  end

  // Receiver
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_line, rx_fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_in;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end
  assign rx_line = rx_s2_q;
  assign rx_fall = rx_s3_q && !rx_s2_q;

  autr_pkg::autr_rx_state_e rx_state_q;
  logic [3:0] rx_cnt_q, rx_cn, rx_bitn_q, rx_nbits;
  logic [1:0] smp_q;
  logic [8:0] rx_shift_reg;
  logic [7:0] rx_data;
  logic rx_eval, rx_val, rx_wrap, rx_push_q;
  logic [8:0] rx_push_data_q;

  assign rx_cn = rx_cnt_q + 4'h1;
  assign rx_wrap = tick_q && rx_cnt_q == bit_last;
  assign rx_eval = tick_q && (baud_speed_select ? rx_cn == `AUTR_SMP_HS
    : rx_cn == `AUTR_SMP_C);
  assign rx_val = baud_speed_select ? rx_line
    : (smp_q[1] & smp_q[0]) | (smp_q[1] & rx_line) | (smp_q[0] & rx_line);
  assign rx_nbits = (mode == `AUTR_MODE_7N) ? 4'h7
    : (mode == `AUTR_MODE_8N) ? 4'h8 : 4'h9;

  always_comb begin
    case (rx_nbits)
      4'h7: rx_data = {1'b0, rx_shift_reg[8:2]};
      4'h8: rx_data = rx_shift_reg[8:1];
      default: rx_data = rx_shift_reg[7:0];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_state_q <= autr_pkg::RX_IDLE;
      rx_cnt_q <= '0;
      rx_bitn_q <= '0;
      smp_q <= '0;
      rx_shift_reg <= '0;
      rx_push_q <= 1'b0;
      rx_push_data_q <= '0;
    end else begin
      rx_push_q <= 1'b0;
      if (rx_state_q != autr_pkg::RX_IDLE && tick_q) begin
        rx_cnt_q <= rx_wrap ? 4'h0 : rx_cn;
        if (!baud_speed_select && (rx_cn == `AUTR_EARLY_A
            || rx_cn == `AUTR_SMP_A || rx_cn == `AUTR_SMP_B)) begin
          smp_q <= {smp_q[0], rx_line};
        end
      end
      case (rx_state_q)
        autr_pkg::RX_IDLE: begin
          if (rx_fall) begin
            rx_cnt_q <= '0;
            rx_state_q <= autr_pkg::RX_START;
          end
        end
        autr_pkg::RX_START: begin
          if (tick_q && !baud_speed_select && rx_cn == `AUTR_EARLY_B
              && smp_q[0] && rx_line) begin
            rx_state_q <= autr_pkg::RX_IDLE;
          end else if (rx_eval && rx_val) begin
            rx_state_q <= autr_pkg::RX_IDLE;
          end else if (rx_wrap) begin
            rx_bitn_q <= '0;
            rx_state_q <= autr_pkg::RX_DATA;
          end
        end
        autr_pkg::RX_DATA: begin
          if (rx_eval) begin
            rx_shift_reg <= {rx_val, rx_shift_reg[8:1]};
          end
          if (rx_wrap) begin
            rx_bitn_q <= rx_bitn_q + 4'h1;
            if (rx_bitn_q == rx_nbits - 4'h1) begin
              rx_state_q <= autr_pkg::RX_STOP;
            end
          end
        end
        autr_pkg::RX_STOP: begin
          if (rx_eval) begin
            rx_push_q <= 1'b1;
            rx_push_data_q <= {!rx_val, rx_data};
            rx_state_q <= autr_pkg::RX_IDLE;
          end
        end
        default: rx_state_q <= autr_pkg::RX_IDLE;
      endcase
    end
  end

  logic [8:0] rx_head;
  logic [1:0] rx_count;
  logic rx_pop, rd_rxb, rd_ok;
  logic [31:0] rd_word;

  assign rd_rxb = s_axi_araddr[7:0] == `AUTR_OFS_RXB;
  assign rx_pop = ar_take && rd_rxb;

  autr_rx_fifo #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!module_en),
    .wr_valid(rx_push_q),
    .wr_data(rx_push_data_q),
    .rd_pop(rx_pop),
    .rd_data_q(rx_head),
    .count_q(rx_count)
  );

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:0])
      `AUTR_OFS_CTRL: rd_word[11:0] = ctrl_q;
      `AUTR_OFS_BAUD: rd_word[15:0] = baud_divisor_q;
      `AUTR_OFS_TXB: rd_word = '0;
      `AUTR_OFS_RXB: begin
        rd_word[8:0] = rx_head;
        rd_word[`AUTR_RXB_VALID] = rx_count != 2'h0;
      end
      `AUTR_OFS_STAT: begin
        rd_word[`AUTR_STAT_TXFREE] = tx_free;
        rd_word[`AUTR_STAT_TXMT] = tx_empty;
        rd_word[`AUTR_STAT_RXAVAIL] = rx_count != 2'h0;
        rd_word[`AUTR_STAT_FERR] = rx_head[`AUTR_RXB_FERR];
        rd_word[`AUTR_STAT_RXFULL] = rx_count == 2'h2;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `AUTR_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `AUTR_RESP_OKAY : `AUTR_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !ar_take && !(s_axi_rvalid && !s_axi_rready);
    end
  end

endmodule : autr_core

`default_nettype wire

// ===== verif/autr_chk.sv
// Bus handshake and pin drive checks for the serial core
`timescale 1ns/1ps
`default_nettype none
module autr_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_direction_ctrl,
  input wire logic tx_oe_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (ar_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  a_aw_refused: assert property
    (aw_w_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_ar_refused: assert property (ar_taken |=> !s_axi_arready)
    else $error("read accepted while busy");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted with data pending");
  a_oe_follow_dir: assert property
    (!pin_direction_ctrl |=> tx_oe_q) else $error("tx pin not driven");
endmodule : autr_chk
`default_nettype wire

// ===== verif/autr_peer.sv
// Remote serial peer: frame sender and receiver
`timescale 1ns/1ps
`default_nettype none
module autr_peer (
  input wire logic aclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'h1;
  task send(input logic [8:0] v, input int n, input logic s, input int bc);
    rx_line <= 1'h0;
    repeat (bc) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rx_line <= v[i];
      repeat (bc) @(posedge aclk);
    end
    rx_line <= s;
    repeat (bc) @(posedge aclk);
    rx_line <= 1'h1;
    repeat (bc) @(posedge aclk);
  endtask : send
  task pulse(input int k);
    rx_line <= 1'h0;
    repeat (k) @(posedge aclk);
    rx_line <= 1'h1;
    repeat (40) @(posedge aclk);
  endtask : pulse
  // Waits for a start edge, samples mid-bit; w counts the wait
  task recv(input int n, input int bc, output logic [8:0] v,
    output logic s, output int w);
    v = '0;
    w = 0;
    while (tx_line !== 1'h0 && w < 4000) begin
      @(posedge aclk);
      w++;
    end
    repeat (bc / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(posedge aclk);
      v[i] = tx_line;
    end
    repeat (bc) @(posedge aclk);
    s = tx_line;
  endtask : recv
endmodule : autr_peer
`default_nettype wire

// ===== verif/test_async_uart_tx_rx.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module test_async_uart_tx_rx;
  localparam int BC = 16;
  logic aclk = 1'h0, aresetn = 1'h0, pdc = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, c;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, tx_out, tx_oe, tx_irq;
  logic rx_line, ps, p;
  logic [1:0] bresp, rresp, r;
  logic [8:0] pd, e;
  int w, n, bad_count = 0, check_count = 0;
  always #5 aclk = ~aclk;
  autr_core uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_direction_ctrl(pdc), .rx_in(rx_line), .tx_out_q(tx_out),
    .tx_oe_q(tx_oe), .tx_irq_q(tx_irq));
  autr_peer peer (.aclk(aclk), .tx_line(tx_out), .rx_line(rx_line));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd
  task stop_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #800000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge aclk);
    chk({tx_out, tx_oe, tx_irq}, 32'h4, "pins in reset");
    aresetn <= 1'h1;
    rd(8'h00);
    chk(d, 32'h0, "ctrl reset");
    rd(8'h04);
    chk(d, 32'h0, "baud reset");
    rd(8'h14);
    chk(r, 32'h2, "unmapped read");
    wr(8'h14, 32'h5);
    chk(r, 32'h2, "unmapped write");
    pdc <= 1'h1;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h407);
    rd(8'h10);
    chk(d & 32'h3, 32'h3, "stat idle");
    chk(tx_irq, 32'h1, "irq free");
    for (int m = 0; m < 4; m++) begin
      c = 8'hb5;
      p = (m == 3) ? ^c : ~^c;
      n = (m == 1) ? 7 : (m > 1) ? 9 : 8;
      e = (m == 1) ? {2'h0, c[6:0]} : (m > 1) ? {p, c} : {1'h0, c};
      wr(8'h00, 32'h407 | (m << 4));
      fork
        peer.recv(n, BC, pd, ps, w);
        wr(8'h08, {24'h0, c});
        peer.send(e, n, 1'h1, BC);
      join
      chk(pd, e, "tx char");
      chk(ps, 32'h1, "tx stop");
      rd(8'h0c);
      chk(d, 32'h200 | e[7:0], "rx char");
    end
    wr(8'h00, 32'h407);
    fork
      begin
        peer.recv(8, BC, pd, ps, w);
        chk(pd, 32'h3c, "first char");
        peer.recv(8, BC, pd, ps, w);
        chk(pd, 32'hc3, "queued char");
        chk(w > 5 && w < 11, 32'h1, "frame gap");
      end
      begin
        wr(8'h08, 32'h3c);
        wr(8'h08, 32'hc3);
        rd(8'h10);
        chk(d & 32'h3, 32'h0, "stat busy");
        chk({tx_irq, tx_oe}, 32'h1, "irq oe busy");
      end
    join
    repeat (20) @(posedge aclk);
    rd(8'h10);
    chk(d & 32'h3, 32'h3, "stat done");
    wr(8'h00, 32'h3);
    rd(8'h10);
    chk({d[0], tx_irq}, 32'h2, "free no irq");
    wr(8'h00, 32'h803);
    rd(8'h10);
    chk(tx_irq, 32'h1, "irq empty");
    wr(8'h00, 32'h100);
    repeat (2) @(posedge aclk);
    chk(tx_out, 32'h0, "inverted idle");
    wr(8'h00, 32'h47);
    wr(8'h08, 32'h0);
    repeat (20) @(posedge aclk);
    chk({tx_out, tx_oe}, 32'h2, "mode 4 quiet");
    peer.send(9'h055, 8, 1'h1, BC);
    rd(8'h0c);
    chk(d & 32'h200, 32'h0, "rx off");
    wr(8'h00, 32'h7);
    peer.send(9'h05a, 8, 1'h1, BC);
    peer.send(9'h066, 8, 1'h0, BC);
    peer.send(9'h011, 8, 1'h1, BC);
    rd(8'h10);
    chk(d & 32'h1c, 32'h14, "fifo full");
    rd(8'h0c);
    chk(d, 32'h25a, "head char");
    rd(8'h10);
    chk(d & 32'h8, 32'h8, "ferr head");
    rd(8'h0c);
    chk(d, 32'h366, "ferr char");
    rd(8'h0c);
    chk(d & 32'h200, 32'h0, "fifo empty");
    peer.pulse(1);
    peer.pulse(4);
    rd(8'h0c);
    chk(d & 32'h200, 32'h0, "no char");
    peer.send(9'h0a7, 8, 1'h1, BC);
    rd(8'h0c);
    chk(d, 32'h2a7, "resumed");
    wr(8'h00, 32'h207);
    peer.send(9'h0c3, 8, 1'h1, 4);
    rd(8'h0c);
    chk(d, 32'h2c3, "fast rx");
    stop_test();
  end
endmodule : test_async_uart_tx_rx
bind autr_core autr_chk chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_direction_ctrl(pin_direction_ctrl), .tx_oe_q(tx_oe_q));
`default_nettype wire
